// ### pwm_ramp_cfg.svh
// Constants of the scripted PWM ramp engine
//------------------------------------------------------------
// Function
//------------------------------------------------------------
// Function
// - Fixed 256-cycle PWM period, duty from ramp
// - 8-bit period counter, first ramp to tristating terminate
// - Output high while period <= ramp value
// - Prescaler divides slow clock by 16/512
// - Ramp saturates, all steps still timed
// - Optional interrupt after last ramp step
// - Ramp word fields and 1-63 step interval
// - Zero word restarts, zero interval loads duty
// - Load-duty sets ramp counter from duty field
// - Restart continues at script address zero
// - Jump with zero repeat loops until stop
// - Nonzero repeat count biased by minus one
// - Jump target above 59 does no looping
// - Terminate stops, interrupts, optional tristate output
// - Stop while waiting skips pending terminate
// - Sync takes at least sixteen slow cycles
// - Waiting sync stalls, clears triggers, proceeds
// - Received trigger latched until waited on
// - Sync word wait and send mask fields
// - Active command plus one buffered command
// - Stop during ramp waits for ramp end
`ifndef PWM_RAMP_CFG_SVH
`define PWM_RAMP_CFG_SVH

//------------------------------------------------------------
// Register offsets
//------------------------------------------------------------
`define REG_CTRL        2'h0
`define REG_SCRIPT      2'h1
`define REG_STATUS      2'h2
`define REG_DUTY        2'h3

//------------------------------------------------------------
// Register field positions
//------------------------------------------------------------
`define CTRL_START_LSB  0
`define CTRL_STOP_LSB   4
`define CTRL_RIRQ_LSB   8
`define CTRL_SADDR_LSB  16
`define SCR_DATA_LSB    0
`define SCR_ADDR_LSB    16
`define SCR_CHAN_LSB    24
`define STAT_RUN_LSB    0
`define STAT_END_LSB    4
`define STAT_RAMP_LSB   8
`define STAT_TRIG_LSB   16

//------------------------------------------------------------
// Reset values and timing
//------------------------------------------------------------
`define RIRQ_RESET      3'h0
`define SADDR_RESET     6'h00
`define PRESC_DIV_LO    16
`define PRESC_DIV_HI    512
`define SYNC_CYCLES     16
`define JUMP_MAX        59

`endif

// ### pwm_ramp_pkg.sv
// Types of the scripted PWM ramp engine
package pwm_ramp_pkg;

  typedef enum logic [2:0] {
    K_RAMP    = 3'h0,
    K_DUTY    = 3'h1,
    K_RESTART = 3'h3,
    K_JUMP    = 3'h2,
    K_END     = 3'h6,
    K_SYNC    = 3'h7,
    K_NOP     = 3'h5
  } cmd_kind_type;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } run_state_type;

  typedef struct packed {
    run_state_type state;
    logic [5:0]    pc;
    logic [15:0]   cmd_buf;
    logic          buf_v;
    logic [15:0]   act;
    logic          act_v;
    logic [8:0]    presc;
    logic [5:0]    ivl;
    logic [6:0]    steps;
    logic [7:0]    ramp;
    logic [7:0]    period;
    logic          period_on;
    logic          drive;
    logic [5:0]    loop_left;
    logic          loop_act;
    logic [4:0]    sync_cnt;
    logic          stop_pend;
    logic [2:0]    trig;
  } chan_type;

endpackage

// ### scripted_pwm_ramp_engine.sv
// Three-channel scripted PWM ramp engine with Avalon-MM registers
//
// Added by the designer: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
`include "pwm_ramp_cfg.svh"

module scripted_pwm_ramp_engine
  import pwm_ramp_pkg::*;
#(
  parameter int NCH = 3
) (
  input  wire logic            CLK_SYS,
  input  wire logic            RESET,
  input  wire logic            SLOW_CLK,
  input  wire logic [3:0]      AVS_ADDRESS,
  input  wire logic            AVS_READ,
  input  wire logic            AVS_WRITE,
  input  wire logic [31:0]     AVS_WRITEDATA,
  input  wire logic [3:0]      AVS_BYTEENABLE,
  output logic      [31:0]     AVS_READDATA,
  output logic                 AVS_WAITREQUEST,
  output logic      [NCH-1:0]  PWM_OUT,
  output logic      [NCH-1:0]  PWM_OE_N,
  output logic                 IRQ_N
);

  //------------------------------------------------------------
  // Slow clock synchroniser
  //------------------------------------------------------------
  logic [2:0] slow_q;
  logic [2:0] slow_d;
  logic       tick;

  always_comb begin
    slow_d = {slow_q[1:0], SLOW_CLK};
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      slow_q <= 3'h0;
    end else begin
      slow_q <= slow_d;
    end
  end

  // Rising edge seen on the second and third stages only
  assign tick = slow_q[1] & ~slow_q[2];

  //------------------------------------------------------------
  // Avalon slave
  //------------------------------------------------------------
  logic            ack_q;
  logic            ack_d;
  logic [31:0]     rdata_q;
  logic [31:0]     rdata_d;
  logic            wr_fire;
  logic [2:0]      rirq_en_q;
  logic [2:0]      rirq_en_d;
  logic [5:0]      saddr_q;
  logic [5:0]      saddr_d;
  logic [2:0]      end_flag_q;
  logic [2:0]      end_flag_d;
  logic [2:0]      ramp_flag_q;
  logic [2:0]      ramp_flag_d;
  logic [2:0]      start_p;
  logic [2:0]      stop_p;
  logic [2:0]      end_set;
  logic [2:0]      ramp_set;
  logic [1:0]      reg_sel;
  chan_type        ch_q [NCH];
  chan_type        ch_d [NCH];

  assign reg_sel         = AVS_ADDRESS[3:2];
  // One wait cycle gives registered read data at the accept edge
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
  assign AVS_READDATA    = rdata_q;
  // Partial writes are ignored to keep script words whole
  assign wr_fire         = AVS_WRITE & ack_q & (AVS_BYTEENABLE == 4'hf);
  assign start_p = (wr_fire && reg_sel == `REG_CTRL) ?
                   AVS_WRITEDATA[`CTRL_START_LSB +: 3] : 3'h0;
  assign stop_p  = (wr_fire && reg_sel == `REG_CTRL) ?
                   AVS_WRITEDATA[`CTRL_STOP_LSB +: 3] : 3'h0;

  always_comb begin
    ack_d       = (AVS_READ | AVS_WRITE) & ~ack_q;
    rdata_d     = rdata_q;
    rirq_en_d   = rirq_en_q;
    saddr_d     = saddr_q;
    end_flag_d  = end_flag_q;
    ramp_flag_d = ramp_flag_q;
    if (AVS_READ && !ack_q) begin
      rdata_d = 32'h0;
      unique case (reg_sel)
        `REG_CTRL: begin
          rdata_d[`CTRL_RIRQ_LSB +: 3]  = rirq_en_q;
          rdata_d[`CTRL_SADDR_LSB +: 6] = saddr_q;
        end
        `REG_SCRIPT: begin
          rdata_d = 32'h0;
        end
        `REG_STATUS: begin
          for (int i = 0; i < NCH; i++) begin
            rdata_d[`STAT_RUN_LSB + i]  = (ch_q[i].state == ST_RUN);
            rdata_d[`STAT_TRIG_LSB + 4 * i +: 3] = ch_q[i].trig;
          end
          rdata_d[`STAT_END_LSB +: 3]  = end_flag_q;
          rdata_d[`STAT_RAMP_LSB +: 3] = ramp_flag_q;
        end
        `REG_DUTY: begin
          for (int i = 0; i < NCH; i++) begin
            rdata_d[8 * i +: 8] = ch_q[i].ramp;
          end
        end
      endcase
    end
    if (wr_fire && reg_sel == `REG_CTRL) begin
      rirq_en_d = AVS_WRITEDATA[`CTRL_RIRQ_LSB +: 3];
      saddr_d   = AVS_WRITEDATA[`CTRL_SADDR_LSB +: 6];
    end
    if (wr_fire && reg_sel == `REG_STATUS) begin
      end_flag_d  = end_flag_d & ~AVS_WRITEDATA[`STAT_END_LSB +: 3];
      ramp_flag_d = ramp_flag_d & ~AVS_WRITEDATA[`STAT_RAMP_LSB +: 3];
    end
    // Hardware set wins over a clear in the same cycle
    end_flag_d  = end_flag_d | end_set;
    ramp_flag_d = ramp_flag_d | ramp_set;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ack_q       <= 1'b0;
      rdata_q     <= 32'h0;
      rirq_en_q   <= `RIRQ_RESET;
      saddr_q     <= `SADDR_RESET;
      end_flag_q  <= 3'h0;
      ramp_flag_q <= 3'h0;
    end else begin
      ack_q       <= ack_d;
      rdata_q     <= rdata_d;
      rirq_en_q   <= rirq_en_d;
      saddr_q     <= saddr_d;
      end_flag_q  <= end_flag_d;
      ramp_flag_q <= ramp_flag_d;
    end
  end

  //------------------------------------------------------------
  // Script command files
  //------------------------------------------------------------
  logic [15:0] mem [NCH * 64];
  logic [7:0]  wr_idx;

  assign wr_idx = {AVS_WRITEDATA[`SCR_CHAN_LSB +: 2], AVS_WRITEDATA[`SCR_ADDR_LSB +: 6]};

  always_ff @(posedge CLK_SYS) begin
    if (wr_fire && reg_sel == `REG_SCRIPT && int'(wr_idx) < NCH * 64) begin
      mem[wr_idx] <= AVS_WRITEDATA[`SCR_DATA_LSB +: 16];
    end
  end

  //------------------------------------------------------------
  // Command decode
  //------------------------------------------------------------
  function automatic cmd_kind_type decode(input logic [15:0] w);
    cmd_kind_type k;
    k = K_NOP;
    if (w == 16'h0000) begin
      k = K_RESTART;
    end else if (!w[15]) begin
      k = (w[13:8] == 6'h00) ? K_DUTY : K_RAMP;
    end else if (w[15:13] == 3'h5) begin
      k = K_JUMP;
    end else if (w[15:12] == 4'hc) begin
      k = K_END;
    end else if (w[15:13] == 3'h7) begin
      k = K_SYNC;
    end
    return k;
  endfunction

  //------------------------------------------------------------
  // Channel engines
  //------------------------------------------------------------
  always_comb begin
    chan_type     c;
    cmd_kind_type k;
    logic         done;
    logic [8:0]   lim;
    logic [5:0]   n;
    logic [2:0]   wm;
    logic [2:0]   send [NCH];
    end_set  = 3'h0;
    ramp_set = 3'h0;
    c        = ch_q[0];
    k        = K_NOP;
    done     = 1'b0;
    lim      = 9'h0;
    n        = 6'h0;
    wm       = 3'h0;
    for (int i = 0; i < NCH; i++) begin
      send[i] = 3'h0;
    end
    for (int i = 0; i < NCH; i++) begin
      c    = ch_q[i];
      k    = decode(c.act);
      done = 1'b0;
      // stop deferred while a ramp is active
      if (c.stop_pend && !(c.act_v && k == K_RAMP)) begin
        // dropping the queue skips a pending terminate
        c.state     = ST_IDLE;
        c.act_v     = 1'b0;
        c.buf_v     = 1'b0;
        c.stop_pend = 1'b0;
      end
      if (c.act_v) begin
        unique case (k)
          K_RAMP: begin
            lim = c.act[14] ? 9'(`PRESC_DIV_HI - 1) : 9'(`PRESC_DIV_LO - 1);
            if (c.steps == 7'h0) begin
              done = 1'b1;
            end else if (tick) begin
              if (c.presc == lim) begin
                c.presc = 9'h0;
                if (c.ivl + 6'h1 >= c.act[13:8]) begin
                  c.ivl   = 6'h0;
                  c.steps = c.steps - 7'h1;
                  if (!c.act[7] && c.ramp != 8'hff) begin
                    c.ramp = c.ramp + 8'h1;
                  end else if (c.act[7] && c.ramp != 8'h00) begin
                    c.ramp = c.ramp - 8'h1;
                  end
                  if (c.steps == 7'h0 && rirq_en_q[i]) begin
                    ramp_set[i] = 1'b1;
                  end
                end else begin
                  c.ivl = c.ivl + 6'h1;
                end
              end else begin
                c.presc = c.presc + 9'h1;
              end
            end
          end
          K_DUTY: begin
            c.ramp = c.act[7:0];
            done   = 1'b1;
          end
          K_RESTART: begin
            c.pc    = 6'h00;
            c.buf_v = 1'b0;
            done    = 1'b1;
          end
          K_JUMP: begin
            done = 1'b1;
            if (c.act[5:0] <= 6'(`JUMP_MAX)) begin
              if (c.act[12:7] == 6'h00) begin
                c.pc    = c.act[5:0];
                c.buf_v = 1'b0;
              end else begin
                n = c.loop_act ? c.loop_left : c.act[12:7] - 6'h1;
                if (n == 6'h00) begin
                  c.loop_act = 1'b0;
                end else begin
                  c.loop_left = n - 6'h1;
                  c.loop_act  = 1'b1;
                  c.pc        = c.act[5:0];
                  c.buf_v     = 1'b0;
                end
              end
            end
          end
          K_END: begin
            c.state     = ST_IDLE;
            c.act_v     = 1'b0;
            c.buf_v     = 1'b0;
            c.period_on = c.period_on & ~c.act[11];
            c.drive     = c.drive & ~c.act[11];
            end_set[i]  = 1'b1;
          end
          K_SYNC: begin
            if (tick && c.sync_cnt != 5'(`SYNC_CYCLES)) begin
              c.sync_cnt = c.sync_cnt + 5'h1;
            end
            wm = c.act[9:7];
            // stall until all waited triggers present
            if (c.sync_cnt == 5'(`SYNC_CYCLES) && (c.trig & wm) == wm) begin
              c.trig = c.trig & ~wm;
              done   = 1'b1;
            end
          end
          K_NOP: begin
            done = 1'b1;
          end
        endcase
      end
      if (done) begin
        c.act_v = 1'b0;
      end
      // buffered command moves up without a gap
      if (!c.act_v && c.buf_v && !c.stop_pend) begin
        c.act      = c.cmd_buf;
        c.act_v    = 1'b1;
        c.buf_v    = 1'b0;
        c.presc    = 9'h0;
        c.ivl      = 6'h0;
        c.steps    = c.cmd_buf[6:0];
        c.sync_cnt = 5'h0;
        if (decode(c.cmd_buf) == K_RAMP) begin
          // first ramp starts the period counter
          c.period_on = 1'b1;
          c.drive     = 1'b1;
        end
        if (decode(c.cmd_buf) == K_SYNC) begin
          send[i] = c.cmd_buf[3:1];
        end
      end
      if (c.state == ST_RUN && !c.buf_v && !c.stop_pend) begin
        c.cmd_buf = mem[8'(i * 64) + {2'h0, c.pc}];
        c.buf_v   = 1'b1;
        c.pc      = c.pc + 6'h1;
      end
      if (stop_p[i] && c.state == ST_RUN) begin
        c.stop_pend = 1'b1;
      end
      if (start_p[i]) begin
        c.state     = ST_RUN;
        c.pc        = saddr_q;
        c.act_v     = 1'b0;
        c.buf_v     = 1'b0;
        c.loop_act  = 1'b0;
        c.stop_pend = 1'b0;
      end
      c.period = c.period_on ? c.period + 8'h1 : 8'h00;
      ch_d[i]  = c;
    end
    for (int j = 0; j < NCH; j++) begin
      for (int i = 0; i < NCH; i++) begin
        if (send[i][j]) begin
          ch_d[j].trig[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      for (int i = 0; i < NCH; i++) begin
        ch_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        ch_q[i] <= ch_d[i];
      end
    end
  end

  //------------------------------------------------------------
  // Outputs
  //------------------------------------------------------------
  logic [NCH-1:0] pwm_q;
  logic [NCH-1:0] pwm_d;
  logic [NCH-1:0] oe_n_q;
  logic [NCH-1:0] oe_n_d;
  logic           irq_n_q;
  logic           irq_n_d;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      pwm_d[i]  = ch_q[i].period_on && (ch_q[i].period <= ch_q[i].ramp);
      oe_n_d[i] = ~ch_q[i].drive;
    end
    irq_n_d = ~(|end_flag_q | |ramp_flag_q);
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      pwm_q   <= '0;
      oe_n_q  <= '1;
      irq_n_q <= 1'b1;
    end else begin
      pwm_q   <= pwm_d;
      oe_n_q  <= oe_n_d;
      irq_n_q <= irq_n_d;
    end
  end

  assign PWM_OUT  = pwm_q;
  assign PWM_OE_N = oe_n_q;
  assign IRQ_N    = irq_n_q;

endmodule
`default_nettype wire

// ### pwm_ramp_monitor.sv
// Port checker of the scripted PWM ramp engine
`timescale 1ns/1ns
`default_nettype none
module pwm_ramp_monitor
  import pwm_ramp_pkg::*;
#(
  parameter int NCH = 3
) (
  input wire logic           CLK_SYS,
  input wire logic           RESET,
  input wire logic           SLOW_CLK,
  input wire logic [3:0]     AVS_ADDRESS,
  input wire logic           AVS_READ,
  input wire logic           AVS_WRITE,
  input wire logic [31:0]    AVS_WRITEDATA,
  input wire logic [3:0]     AVS_BYTEENABLE,
  input wire logic [31:0]    AVS_READDATA,
  input wire logic           AVS_WAITREQUEST,
  input wire logic [NCH-1:0] PWM_OUT,
  input wire logic [NCH-1:0] PWM_OE_N,
  input wire logic           IRQ_N
);
  logic       req;
  logic       wr_ok;
  logic       rise;
  logic       pwm0_q;
  logic [9:0] gap_q;
  logic [9:0] gap_d;

  assign req   = AVS_READ || AVS_WRITE;
  assign wr_ok = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE == 4'hf && !AVS_ADDRESS[2];
  assign rise  = PWM_OUT[0] && !pwm0_q;

  // ------------------------------
  // Cycles since last rise
  // ------------------------------
  // A start may restart the period, so it forgives the next gap
  always_comb begin
    gap_d = (gap_q == 10'h3ff) ? gap_q : gap_q + 10'h001;
    if (rise) begin
      gap_d = 10'h001;
    end
    if (wr_ok && AVS_ADDRESS[3:2] == 2'h0 && AVS_WRITEDATA[0]) begin
      gap_d = 10'h3ff;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      gap_q  <= 10'h3ff;
      pwm0_q <= 1'b0;
    end else begin
      gap_q  <= gap_d;
      pwm0_q <= PWM_OUT[0];
    end
  end

  // ------------------------------
  // Assertions
  // ------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);

  a_wait_first: assert property ($rose(req) |-> AVS_WAITREQUEST)
    else $error("request answered without wait state");
  a_wait_one: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request waited too long");
  a_wait_idle: assert property (!req |-> !AVS_WAITREQUEST)
    else $error("waitrequest with no request");
  a_reset_pins: assert property (disable iff (1'b0) RESET |=> PWM_OUT == '0 && &PWM_OE_N && IRQ_N)
    else $error("pins not idle after reset");
  a_rdata_hold: assert property (!AVS_READ |=> $stable(AVS_READDATA))
    else $error("read data moved without read");
  a_irq_clear: assert property ($rose(IRQ_N) |-> $past(wr_ok) || $past(wr_ok, 2))
    else $error("interrupt released without write");
  a_period_gap: assert property (rise |-> gap_q >= 10'd256)
    else $error("pwm period shorter than 256");
  a_rise_bound: assert property ($fell(PWM_OUT[0]) |-> ##[1:255] ($rose(PWM_OUT[0]) || PWM_OE_N[0]))
    else $error("pwm low past period end");
endmodule

bind scripted_pwm_ramp_engine pwm_ramp_monitor #(.NCH(NCH)) i_pwm_ramp_monitor (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .SLOW_CLK(SLOW_CLK), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .PWM_OUT(PWM_OUT), .PWM_OE_N(PWM_OE_N), .IRQ_N(IRQ_N));
`default_nettype wire

// ### pwm_host_model.sv
// Host model driving the register bus
`timescale 1ns/1ns
`default_nettype none
module pwm_host_model
  import pwm_ramp_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        AVS_WAITREQUEST,
  input  wire logic [31:0] AVS_READDATA,
  output logic      [3:0]  AVS_ADDRESS,
  output logic             AVS_READ,
  output logic             AVS_WRITE,
  output logic      [31:0] AVS_WRITEDATA,
  output logic      [3:0]  AVS_BYTEENABLE
);
  initial begin
    AVS_ADDRESS    <= 4'h0;
    AVS_READ       <= 1'b0;
    AVS_WRITE      <= 1'b0;
    AVS_WRITEDATA  <= 32'h0;
    AVS_BYTEENABLE <= 4'h0;
  end

  // Entered just after an edge; returns one edge after release
  task automatic access(input logic r, input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] b, output logic [31:0] q, output logic ok);
    int n;
    n  = 0;
    ok = 1'b0;
    q  = 32'h0;
    AVS_ADDRESS    <= a;
    AVS_READ       <= r;
    AVS_WRITE      <= !r;
    AVS_WRITEDATA  <= d;
    AVS_BYTEENABLE <= b;
    // Waitrequest and read data taken as they stand at each rising edge
    while (!ok && n < 64) begin
      @(posedge CLK_SYS);
      ok = (AVS_WAITREQUEST === 1'b0);
      q  = AVS_READDATA;
      n++;
    end
    // Released lines flip so stale values never look valid
    AVS_READ      <= 1'b0;
    AVS_WRITE     <= 1'b0;
    AVS_ADDRESS   <= ~a;
    AVS_WRITEDATA <= ~d;
    @(posedge CLK_SYS);
  endtask
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench of the scripted PWM ramp engine
`timescale 1ns/1ns
`default_nettype none
module tb
  import pwm_ramp_pkg::*;
;
  logic        clk = 1'b0;
  logic        slow = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  adr;
  logic        rd_s;
  logic        wr_s;
  logic [31:0] wdat;
  logic [3:0]  be;
  logic [31:0] rdat;
  logic        wreq;
  logic [2:0]  pwm;
  logic [2:0]  oe_n;
  logic        irq_n;
  logic [31:0] seed = 32'h0000a1fe;
  logic [31:0] q;
  logic [15:0] jt [5] = '{16'h4000, 16'h0101, 16'ha181, 16'ha1bc, 16'hc000};
  int          bad_count = 0;
  int          comparisons = 0;

  always #50 clk = ~clk;
  // Slow tick of 380 ns, unrelated in phase
  always #190 slow = ~slow;

  scripted_pwm_ramp_engine #(.NCH(3)) i_scripted_pwm_ramp_engine (
    .CLK_SYS(clk), .RESET(rst), .SLOW_CLK(slow), .AVS_ADDRESS(adr), .AVS_READ(rd_s),
    .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .PWM_OUT(pwm), .PWM_OE_N(oe_n), .IRQ_N(irq_n));
  pwm_host_model i_pwm_host_model (
    .CLK_SYS(clk), .AVS_WAITREQUEST(wreq), .AVS_READDATA(rdat), .AVS_ADDRESS(adr),
    .AVS_READ(rd_s), .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be));

  // ------------------------------
  // Helpers
  // ------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] ramp_exp(logic [7:0] s, logic dn, int n);
    int v;
    v = dn ? int'(s) - n : int'(s) + n;
    return (v < 0) ? 8'h00 : (v > 255) ? 8'hff : v[7:0];
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic bus(logic r, logic [3:0] a, logic [31:0] d = 32'h0, logic [3:0] b = 4'hf);
    logic ok;
    i_pwm_host_model.access(r, a, d, b, q, ok);
    if (!ok) begin
      bad_count++;
      complete_run();
    end
  endtask

  task automatic load(logic [1:0] c, logic [5:0] ad, logic [15:0] w);
    bus(1'b0, 4'h4, {6'h00, c, 2'h0, ad, w});
  endtask

  task automatic ctrl(logic [2:0] start, logic [2:0] stop);
    bus(1'b0, 4'h0, {21'h0, 3'h7, 1'b0, stop, 1'b0, start});
  endtask

  task automatic poll(int b, logic v);
    int n;
    n = 0;
    bus(1'b1, 4'h8);
    while (q[b] !== v) begin
      n++;
      if (n > 3000) begin
        bad_count++;
        complete_run();
      end
      bus(1'b1, 4'h8);
    end
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  initial begin
    logic [31:0] r;
    logic [7:0]  d;
    logic [7:0]  e;
    int          n;
    int          hi;
    time         t0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("pins", {pwm, oe_n, irq_n}, 32'h0f);
    @(posedge clk);
    bus(1'b0, 4'h0, 32'h700, 4'h3);
    bus(1'b1, 4'h0);
    check("ctrl", q & 32'h3f0700, 32'h0);
    ctrl(3'h0, 3'h0);
    bus(1'b1, 4'h0);
    check("ctrl", q & 32'h3f0700, 32'h700);
    for (int c = 0; c < 3; c++) begin
      r = rnd();
      d = r[0] ? 8'hff : 8'h00;
      n = 1 + int'(r[3:1]);
      load(c[1:0], 6'h0, {8'h40, d});
      load(c[1:0], 6'h1, {2'b00, 6'h01, r[4], 7'(n)});
      load(c[1:0], 6'h2, 16'hc000);
      t0 = $time;
      ctrl(3'h1 << c, 3'h0);
      poll(4 + c, 1'b1);
      e = ramp_exp(d, r[4], n);
      check("ramp time", $time - t0 >= n * 6080 && $time - t0 < n * 6080 + 3000, 1);
      check("flags", q & (32'h111 << c), 32'h110 << c);
      bus(1'b1, 4'hc);
      check("duty", q[8*c +: 8], e);
      @(negedge clk);
      check("irq", irq_n, 1'b0);
      check("oe", oe_n[c], 1'b0);
      hi = 0;
      repeat (256) begin
        @(negedge clk);
        hi += int'(pwm[c]);
      end
      check("high time", hi, 32'(e) + 1);
      @(posedge clk);
      bus(1'b0, 4'h8, 32'h770);
      @(negedge clk);
      check("irq", irq_n, 1'b1);
      @(posedge clk);
    end
    foreach (jt[i]) load(2'h0, 6'(i), jt[i]);
    ctrl(3'h1, 3'h0);
    poll(4, 1'b1);
    bus(1'b1, 4'hc);
    check("loops", q[7:0], 8'h03);
    for (int i = 0; i < 4; i++) begin
      load(2'h1, 6'(i), i == 2 ? 16'h0000 : jt[i]);
      load(2'h2, 6'(i), i == 2 ? 16'ha001 : jt[i]);
    end
    ctrl(3'h6, 3'h0);
    repeat (1200) @(posedge clk);
    bus(1'b1, 4'hc);
    check("restart", q[15:8] <= 8'h01, 1);
    check("endless", q[23:16] > 8'h08, 1);
    ctrl(3'h0, 3'h6);
    poll(1, 1'b0);
    poll(2, 1'b0);
    check("no end", q & 32'h70, 32'h10);
    load(2'h0, 6'h1, 16'h4101);
    load(2'h0, 6'h2, 16'hc000);
    bus(1'b0, 4'h8, 32'h770);
    t0 = $time;
    ctrl(3'h1, 3'h0);
    repeat (20) @(posedge clk);
    ctrl(3'h0, 3'h1);
    poll(0, 1'b0);
    check("stop wait", $time - t0 >= 512 * 380, 1);
    check("stop flags", q & 32'h111, 32'h100);
    load(2'h1, 6'h0, 16'he080);
    load(2'h1, 6'h1, 16'hc800);
    load(2'h2, 6'h0, 16'he080);
    load(2'h2, 6'h1, 16'hc000);
    load(2'h0, 6'h0, 16'he00c);
    bus(1'b0, 4'h8, 32'h770);
    ctrl(3'h6, 3'h0);
    repeat (200) @(posedge clk);
    ctrl(3'h0, 3'h4);
    poll(2, 1'b0);
    check("waiting", q & 32'h66, 32'h02);
    @(negedge clk);
    check("irq", irq_n, 1'b1);
    @(posedge clk);
    t0 = $time;
    ctrl(3'h1, 3'h0);
    poll(4, 1'b1);
    // Sync of 16 ticks then a 512-tick ramp before the end flag
    check("send time", $time - t0 >= 527 * 380 && $time - t0 < 528 * 380 + 3000, 1);
    poll(5, 1'b1);
    check("triggers", q & 32'h07770000, 32'h01000000);
    @(negedge clk);
    check("tristate", oe_n[1], 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
